/* hw/slr_blinker.sv */
`include "slr_defines.svh"

// square wave with programmable half period, plus tick pulse at each toggle
module slr_blinker #(
    parameter int HALF_W = 32
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [HALF_W-1:0] i_half,
    output logic o_wave,
    output logic o_tick
);
    logic [HALF_W-1:0] count;

    if (HALF_W < 2) begin
        $error("slr_blinker: HALF_W too small");
    end

    // true on the last count of a half period
    function automatic logic at_end(input logic [HALF_W-1:0] c, input logic [HALF_W-1:0] h);
        return c + 1'b1 >= h;
    endfunction

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            count <= '0;
        end else if (at_end(count, i_half)) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wave <= 1'b0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= at_end(count, i_half);
            if (at_end(count, i_half)) begin
                o_wave <= ~o_wave;
            end
        end
    end
endmodule

/* hw/slr_defines.svh */
`ifndef SLR_DEFINES_SVH
`define SLR_DEFINES_SVH

`define SLR_CLK_HZ 50000000
`define SLR_HOLD_TIME_S 3
`define SLR_HOLD_CYCLES (`SLR_HOLD_TIME_S * `SLR_CLK_HZ)
`define SLR_DEBOUNCE_TIME_MS 10
`define SLR_DEBOUNCE_CYCLES (`SLR_DEBOUNCE_TIME_MS * (`SLR_CLK_HZ / 1000))
`define SLR_FAST_HALF_MS 100
`define SLR_SLOW_HALF_MS 500
`define SLR_SLOWER_HALF_MS 1000
`define SLR_FLASH_MS 50
`define SLR_MS_CYCLES (`SLR_CLK_HZ / 1000)
`define SLR_MAX_MODULES 4
`define SLR_PIN_W 8
`define SLR_LL_LOW 32'ha9fe0001
`define SLR_LL_HIGH 32'ha9fefffe
`define SLR_LL_PREFIX 16'ha9fe

`endif

/* hw/slr_pin_map.sv */
`include "slr_defines.svh"

// prefix sum of per-module pin counts: first pin number of each module
module slr_pin_map #(
    parameter int MODS = `SLR_MAX_MODULES,
    parameter int PIN_W = `SLR_PIN_W
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [MODS-1:0] i_present,
    input wire logic [MODS*PIN_W-1:0] i_pins,
    output logic [MODS*PIN_W-1:0] o_base,
    output logic [PIN_W-1:0] o_total
);
    logic [MODS*PIN_W-1:0] next_base;
    logic [PIN_W-1:0] next_total;

    always_comb begin
        next_total = '0;
        next_base = '0;
        for (int m = 0; m < MODS; m++) begin
            next_base[m*PIN_W +: PIN_W] = next_total;
            if (i_present[m]) begin
                next_total = next_total + i_pins[m*PIN_W +: PIN_W];
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_base <= '0;
            o_total <= '0;
        end else begin
            o_base <= next_base;
            o_total <= next_total;
        end
    end
endmodule

/* hw/slr_pkg.sv */
package slr_pkg;
    typedef enum logic [3:0] {
        SLR_LINK_OFF = 4'h1,
        SLR_LINK_WAIT_LEASE = 4'h2,
        SLR_LINK_READY = 4'h4,
        SLR_LINK_CONNECTED = 4'h8
    } slr_link_t;

    typedef enum logic [3:0] {
        SLR_CH_ACTIVE = 4'h1,
        SLR_CH_PASSIVE = 4'h2,
        SLR_CH_BUS_OFF = 4'h4,
        SLR_CH_IDLE = 4'h8
    } slr_chan_t;

    typedef enum logic [3:0] {
        SLR_RST_IDLE = 4'h1,
        SLR_RST_SHORT = 4'h2,
        SLR_RST_LONG = 4'h4,
        SLR_RST_DONE = 4'h8
    } slr_rst_t;
endpackage

/* hw/slr_status.sv */
`include "slr_defines.svh"

// How it works
// - power lamp steady on while supplied and running normally
// - link lamp flashes fast while waiting for an address lease
// - link lamp flashes slowly when ready for a remote connection
// - link lamp steady on while a host is connected
// - error passive channel: red blinks, yellow blinks
// - bus-off channel: red blinks slower, yellow keeps blinking
// - module power lamp steady when talking, flashing when not
// - at most four expansion modules on the chain
// - expansion pins numbered consecutively from zero, first module first
// - each module continues after the last number of its left neighbour
// - chain change renumbers pins and forces all outputs to zero; the code only pulses o_outputs_clear and leaves its outputs as they are
// - button press lights channel one red at once while the power lamp is on
// - release before three seconds resets modules only
// - held three seconds: channels one and two red; release also factory net
// - link-local fallback address within 169.254.0.1 to 169.254.255.254
module slr_status #(
    parameter int CHANS = 4,
    parameter int MODS = `SLR_MAX_MODULES,
    parameter int PIN_W = `SLR_PIN_W,
    parameter logic [31:0] HOLD_CYCLES = 32'(`SLR_HOLD_CYCLES),
    parameter logic [31:0] DEBOUNCE_CYCLES = 32'(`SLR_DEBOUNCE_CYCLES),
    parameter logic [31:0] FAST_HALF = 32'(`SLR_FAST_HALF_MS * `SLR_MS_CYCLES),
    parameter logic [31:0] SLOW_HALF = 32'(`SLR_SLOW_HALF_MS * `SLR_MS_CYCLES),
    parameter logic [31:0] SLOWER_HALF = 32'(`SLR_SLOWER_HALF_MS * `SLR_MS_CYCLES),
    parameter logic [31:0] FLASH_CYCLES = 32'(`SLR_FLASH_MS * `SLR_MS_CYCLES)
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_power_good,
    input wire logic [3:0] i_link_state,
    input wire logic [15:0] i_link_local_host,
    input wire logic [CHANS*4-1:0] i_chan_state,
    input wire logic [CHANS-1:0] i_error_frame,
    input wire logic i_reset_button,
    input wire logic [MODS-1:0] i_mod_present,
    input wire logic [MODS-1:0] i_mod_comm,
    input wire logic [MODS*PIN_W-1:0] i_mod_pins,
    output logic o_power_ok_lamp,
    output logic o_link_status_lamp,
    output logic [31:0] o_link_local_fallback,
    output logic [CHANS-1:0] o_chan_red,
    output logic [CHANS-1:0] o_chan_yellow,
    output logic [MODS-1:0] o_mod_power_lamp,
    output logic [MODS*PIN_W-1:0] o_pin_base,
    output logic [PIN_W-1:0] o_pin_total,
    output logic o_outputs_clear,
    output logic o_reset_modules,
    output logic o_factory_net
);
    // elaboration checks on the parameters
    if (MODS < 1 || MODS > `SLR_MAX_MODULES) begin
        $error("slr_status: MODS out of range");
    end
    if (CHANS < 2) begin
        $error("slr_status: need two channels for reset pattern");
    end
    if (PIN_W < 2) begin
        $error("slr_status: PIN_W too narrow");
    end
    if (HOLD_CYCLES <= DEBOUNCE_CYCLES) begin
        $error("slr_status: hold threshold too short");
    end
    if (FAST_HALF >= SLOW_HALF || SLOW_HALF >= SLOWER_HALF) begin
        $error("slr_status: lamp rates not distinct");
    end
    if (FLASH_CYCLES == 32'h0 || FLASH_CYCLES >= FAST_HALF) begin
        $error("slr_status: error flash not short");
    end

    logic fast_wave, slow_wave, slower_wave;

    slr_blinker #(.HALF_W(32)) u_fast (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_half(FAST_HALF),
        .o_wave(fast_wave),
        .o_tick()
    );
    slr_blinker #(.HALF_W(32)) u_slow (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_half(SLOW_HALF),
        .o_wave(slow_wave),
        .o_tick()
    );
    slr_blinker #(.HALF_W(32)) u_slower (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_half(SLOWER_HALF),
        .o_wave(slower_wave),
        .o_tick()
    );

    // power lamp
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_power_ok_lamp <= 1'b0;
        end else begin
            o_power_ok_lamp <= i_power_good;
        end
    end

    // link lamp
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_link_status_lamp <= 1'b0;
        end else begin
            case (i_link_state)
                slr_pkg::SLR_LINK_WAIT_LEASE: o_link_status_lamp <= fast_wave;
                slr_pkg::SLR_LINK_READY: o_link_status_lamp <= slow_wave;
                slr_pkg::SLR_LINK_CONNECTED: o_link_status_lamp <= 1'b1;
                default: o_link_status_lamp <= 1'b0;
            endcase
        end
    end

    // link-local fallback address, host part kept inside the legal range
    function automatic logic [15:0] clamp_host(input logic [15:0] h);
        if (h == 16'h0000) begin
            clamp_host = 16'h0001;
        end else if (h == 16'hffff) begin
            clamp_host = 16'hfffe;
        end else begin
            clamp_host = h;
        end
    endfunction

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_link_local_fallback <= `SLR_LL_LOW;
        end else begin
            o_link_local_fallback <= {`SLR_LL_PREFIX, clamp_host(i_link_local_host)};
        end
    end

    // reset button: debounce and hold timing
    logic btn_stable;
    logic [31:0] db_count;
    logic [31:0] hold_count;
    slr_pkg::slr_rst_t rst_state;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            btn_stable <= 1'b0;
            db_count <= '0;
        end else if (i_reset_button == btn_stable) begin
            db_count <= '0;
        end else if (db_count + 32'h1 >= DEBOUNCE_CYCLES) begin
            btn_stable <= i_reset_button;
            db_count <= '0;
        end else begin
            db_count <= db_count + 32'h1;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rst_state <= slr_pkg::SLR_RST_IDLE;
            hold_count <= '0;
        end else begin
            case (rst_state)
                slr_pkg::SLR_RST_IDLE: begin
                    hold_count <= '0;
                    if (btn_stable && o_power_ok_lamp) begin
                        rst_state <= slr_pkg::SLR_RST_SHORT;
                    end
                end
                slr_pkg::SLR_RST_SHORT: begin
                    hold_count <= hold_count + 32'h1;
                    if (!btn_stable) begin
                        rst_state <= slr_pkg::SLR_RST_DONE;
                    end else if (hold_count + 32'h1 >= HOLD_CYCLES) begin
                        rst_state <= slr_pkg::SLR_RST_LONG;
                    end
                end
                slr_pkg::SLR_RST_LONG: begin
                    if (!btn_stable) begin
                        rst_state <= slr_pkg::SLR_RST_DONE;
                    end
                end
                slr_pkg::SLR_RST_DONE: rst_state <= slr_pkg::SLR_RST_IDLE;
                default: rst_state <= slr_pkg::SLR_RST_IDLE;
            endcase
        end
    end

    // reset actions: one-cycle pulses on release
    logic long_seen;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            long_seen <= 1'b0;
            o_reset_modules <= 1'b0;
            o_factory_net <= 1'b0;
        end else begin
            o_reset_modules <= 1'b0;
            o_factory_net <= 1'b0;
            if (rst_state == slr_pkg::SLR_RST_LONG) begin
                long_seen <= 1'b1;
            end
            if (rst_state == slr_pkg::SLR_RST_DONE) begin
                o_reset_modules <= 1'b1;
                o_factory_net <= long_seen;
                long_seen <= 1'b0;
            end
        end
    end

    // per-channel lamps
    logic [CHANS-1:0][31:0] flash_count;

    // reset pattern: channel one red on a short hold, channels one and two on a long one
    function automatic logic reset_red(input slr_pkg::slr_rst_t st, input int c);
        case (st)
            slr_pkg::SLR_RST_SHORT: reset_red = (c == 0);
            slr_pkg::SLR_RST_LONG: reset_red = (c < 2);
            default: reset_red = 1'b0;
        endcase
    endfunction

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            flash_count <= '0;
        end else begin
            for (int c = 0; c < CHANS; c++) begin
                if (i_error_frame[c]) begin
                    flash_count[c] <= FLASH_CYCLES;
                end else if (flash_count[c] != 32'h0) begin
                    flash_count[c] <= flash_count[c] - 32'h1;
                end
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_chan_red <= '0;
            o_chan_yellow <= '0;
        end else begin
            for (int c = 0; c < CHANS; c++) begin
                case (i_chan_state[c*4 +: 4])
                    slr_pkg::SLR_CH_PASSIVE: begin
                        o_chan_red[c] <= fast_wave;
                        o_chan_yellow[c] <= fast_wave;
                    end
                    slr_pkg::SLR_CH_BUS_OFF: begin
                        o_chan_red[c] <= slower_wave;
                        o_chan_yellow[c] <= fast_wave;
                    end
                    default: begin
                        o_chan_red[c] <= (flash_count[c] != 32'h0);
                        o_chan_yellow[c] <= 1'b0;
                    end
                endcase
                if (reset_red(rst_state, c)) begin
                    o_chan_red[c] <= 1'b1;
                end
            end
        end
    end

    // expansion module lamps
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_mod_power_lamp <= '0;
        end else begin
            for (int m = 0; m < MODS; m++) begin
                o_mod_power_lamp[m] <= i_mod_present[m] & (i_mod_comm[m] | fast_wave);
            end
        end
    end

    // pin numbering and chain change detection
    slr_pin_map #(.MODS(MODS), .PIN_W(PIN_W)) u_map (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_present(i_mod_present),
        .i_pins(i_mod_pins),
        .o_base(o_pin_base),
        .o_total(o_pin_total)
    );

    logic [MODS-1:0] last_present;
    logic [MODS*PIN_W-1:0] last_pins;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            last_present <= '0;
            last_pins <= '0;
            o_outputs_clear <= 1'b0;
        end else begin
            last_present <= i_mod_present;
            last_pins <= i_mod_pins;
            o_outputs_clear <= (last_present != i_mod_present) || (last_pins != i_mod_pins);
        end
    end
endmodule

/* test/slr_operator.sv */
// operator at the reset button: bounces for a few cycles on every press and release
module slr_operator (
    input wire logic i_clock,
    input wire logic i_lamp,
    input wire logic i_want,
    input wire logic i_force,
    output logic o_button
);
    timeunit 1ns;
    timeprecision 1ps;
    logic held = 1'b0;
    logic [2:0] bounce = 3'h0;
    always @(posedge i_clock) begin
        if (i_want != held && (i_lamp || i_force || !i_want)) begin
            held <= i_want;
            bounce <= 3'h5;
        end else if (bounce != 3'h0) begin
            bounce <= bounce - 3'h1;
        end
    end
    assign o_button = held ^ bounce[0];
endmodule

/* test/slr_status_monitor.sv */
module slr_status_monitor #(
    parameter int CHANS = 4,
    parameter int MODS = 4,
    parameter int PIN_W = 8,
    parameter logic [31:0] HOLD_CYCLES = 32'hc8,
    parameter logic [31:0] DEBOUNCE_CYCLES = 32'h4
) (
    input logic i_clock,
    input logic i_sys_rst,
    input logic i_power_good,
    input logic [3:0] i_link_state,
    input logic [CHANS*4-1:0] i_chan_state,
    input logic [CHANS-1:0] i_error_frame,
    input logic i_reset_button,
    input logic [MODS-1:0] i_mod_present,
    input logic [MODS-1:0] i_mod_comm,
    input logic [MODS*PIN_W-1:0] i_mod_pins,
    input logic o_power_ok_lamp,
    input logic o_link_status_lamp,
    input logic [31:0] o_link_local_fallback,
    input logic [CHANS-1:0] o_chan_red,
    input logic [MODS-1:0] o_mod_power_lamp,
    input logic [MODS*PIN_W-1:0] o_pin_base,
    input logic o_outputs_clear,
    input logic o_reset_modules,
    input logic o_factory_net
);
    logic [31:0] hi_cnt;
    logic [MODS*PIN_W-1:0] exp_base;
    logic [MODS*PIN_W-1:0] next_base;
    logic [PIN_W-1:0] sum;
    always_comb begin
        sum = '0;
        for (int m = 0; m < MODS; m++) begin
            next_base[m*PIN_W +: PIN_W] = sum;
            if (i_mod_present[m]) sum = sum + i_mod_pins[m*PIN_W +: PIN_W];
        end
    end
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) exp_base <= '0;
        else exp_base <= next_base;
    end
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) hi_cnt <= '0;
        else if (!i_reset_button) hi_cnt <= '0;
        else if (hi_cnt != '1) hi_cnt <= hi_cnt + 32'h1;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    power_lamp_a: assert property (!$past(i_sys_rst) |-> o_power_ok_lamp == $past(i_power_good))
        else $error("power lamp wrong");
    link_steady_a: assert property (!$past(i_sys_rst) && $past(i_link_state) == 4'h8 |-> o_link_status_lamp)
        else $error("link lamp not steady");
    mod_lamp_a: assert property (!$past(i_sys_rst) |-> &((~$past(i_mod_present) | ~$past(i_mod_comm)
        | o_mod_power_lamp) & ($past(i_mod_present) | ~o_mod_power_lamp))) else $error("module lamp wrong");
    pin_base_a: assert property (o_pin_base == exp_base)
        else $error("pin numbering wrong");
    clear_pulse_a: assert property (!$past(i_sys_rst) && ($changed(i_mod_present)
        || $changed(i_mod_pins)) |=> o_outputs_clear) else $error("outputs not cleared");
    press_red_a: assert property (hi_cnt == DEBOUNCE_CYCLES + 4 && o_power_ok_lamp |-> o_chan_red[0])
        else $error("press lamp missing");
    long_red_a: assert property (hi_cnt == DEBOUNCE_CYCLES + HOLD_CYCLES + 4 |-> &o_chan_red[1:0])
        else $error("long press lamps missing");
    factory_pair_a: assert property (o_factory_net |-> o_reset_modules)
        else $error("factory reset alone");
    clear_quiet_a: assert property (!$past(i_sys_rst) && $stable(i_mod_present)
        && $stable(i_mod_pins) |=> !o_outputs_clear) else $error("spurious outputs clear");
    reset_pulse_a: assert property (o_reset_modules |=> !o_reset_modules)
        else $error("module reset too long");
    flash_red_a: assert property (i_error_frame[2] && i_chan_state[11:8] == 4'h1 |-> ##2 o_chan_red[2] [*4])
        else $error("error flash missing");
    fallback_range_a: assert property (o_link_local_fallback[31:16] == 16'ha9fe
        && o_link_local_fallback[15:0] != 16'h0 && o_link_local_fallback[15:0] != 16'hffff)
        else $error("fallback address out of range");
endmodule

bind slr_status slr_status_monitor #(.CHANS(CHANS), .MODS(MODS), .PIN_W(PIN_W),
    .HOLD_CYCLES(HOLD_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_mon (.*);

/* test/slr_status_tb.sv */
module slr_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int F = 32'h8;
    localparam int S = 32'h20;
    localparam int SL = 32'h40;
    localparam int FL = 32'h6;
    logic i_clock = 1'b0, i_sys_rst = 1'b1, i_power_good = 1'b0, i_reset_button;
    logic [3:0] i_link_state = 4'h1, i_error_frame = 4'h0, i_mod_present = 4'h0;
    logic [3:0] i_mod_comm = 4'h0, o_chan_red, o_chan_yellow, o_mod_power_lamp, acc_and, acc_or;
    logic [15:0] i_link_local_host = 16'h0, i_chan_state = 16'h8888, h;
    logic [31:0] i_mod_pins = 32'h0, o_link_local_fallback, o_pin_base;
    logic [39:0] eb;
    logic [7:0] o_pin_total;
    logic o_power_ok_lamp, o_link_status_lamp, o_outputs_clear, o_reset_modules, o_factory_net;
    logic want = 1'b0, force_b = 1'b0, y;
    int n_fail = 0, num_checks = 0, seed = 77, n, k;
    slr_status #(.HOLD_CYCLES(32'hc8), .DEBOUNCE_CYCLES(32'h4), .FAST_HALF(F), .SLOW_HALF(S),
        .SLOWER_HALF(SL), .FLASH_CYCLES(FL)) dut (.*);
    slr_operator op (.i_clock(i_clock), .i_lamp(o_power_ok_lamp), .i_want(want),
        .i_force(force_b), .o_button(i_reset_button));
    always #10 i_clock = ~i_clock;
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h got %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge i_clock);
        #1;
    endtask
    function automatic logic lamp(input int w);
        return w == 0 ? o_link_status_lamp : w == 1 ? o_chan_red[3] : o_chan_yellow[3];
    endfunction
    // skip the change a mode switch may cause and the partial half period after it, then time one full half period
    task automatic half(input int w, input int hp);
        logic v;
        for (int r = 0; r < 3; r++) begin
            v = lamp(w);
            n = 0;
            while (lamp(w) === v && n < 200) begin
                cyc(1);
                n++;
            end
        end
        chk("half period", 32'h1, 32'(n >= hp - 1 && n <= hp + 1));
    endtask
    function automatic logic [39:0] exp_base(input logic [3:0] p, input logic [31:0] pins);
        logic [7:0] s;
        s = 8'h0;
        for (int m = 0; m < 4; m++) begin
            exp_base[m*8 +: 8] = s;
            if (p[m]) s = s + pins[m*8 +: 8];
        end
        exp_base[39:32] = s;
    endfunction
    task automatic press(input int hold, input logic [1:0] red, input logic fac);
        want = 1'b1;
        cyc(hold);
        chk("reset lamps", 32'(red), 32'(o_chan_red[1:0]));
        want = 1'b0;
        k = 0;
        while (o_reset_modules !== 1'b1 && k < 60) begin
            cyc(1);
            k++;
        end
        chk("module reset", 32'h1, 32'(o_reset_modules));
        chk("factory reset", 32'(fac), 32'(o_factory_net));
        cyc(6);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10000) @(posedge i_clock);
        n_fail++;
        tally_and_finish;
    end
    initial begin
        cyc(6);
        i_sys_rst = 1'b0;
        i_power_good = 1'b1;
        cyc(2);
        chk("power lamp", 32'h1, 32'(o_power_ok_lamp));
        for (int j = 0; j < 3; j++) begin
            h = j == 0 ? 16'h0 : j == 1 ? 16'hffff : 16'($random(seed));
            i_link_local_host = h;
            cyc(1);
            chk("fallback", {16'ha9fe, h == 0 ? 16'h1 : h == 16'hffff ? 16'hfffe : h},
                o_link_local_fallback);
        end
        i_link_state = 4'h2;
        half(0, F);
        i_link_state = 4'h4;
        half(0, S);
        i_link_state = 4'h8;
        cyc(2);
        chk("link steady", 32'h1, 32'(o_link_status_lamp));
        i_chan_state[15:12] = 4'h2;
        half(1, F);
        half(2, F);
        i_chan_state[15:12] = 4'h4;
        half(1, SL);
        half(2, F);
        i_chan_state = 16'h8188;
        cyc(2);
        y = o_chan_yellow[2];
        i_error_frame[2] = 1'b1;
        cyc(1);
        i_error_frame[2] = 1'b0;
        cyc(2);
        chk("error flash", 32'h1, 32'(o_chan_red[2]));
        cyc(FL + 4);
        chk("flash end", 32'h0, 32'(o_chan_red[2]));
        chk("yellow kept", 32'(y), 32'(o_chan_yellow[2]));
        repeat (6) begin
            i_mod_present = 4'($random(seed));
            i_mod_comm = 4'($random(seed));
            i_mod_pins = $random(seed) & 32'h3f3f3f3f;
            eb = exp_base(i_mod_present, i_mod_pins);
            cyc(1);
            chk("outputs clear", 32'h1, 32'(o_outputs_clear));
            chk("pin base", eb[31:0], o_pin_base);
            chk("pin total", 32'(eb[39:32]), 32'(o_pin_total));
            acc_and = 4'hf;
            acc_or = 4'h0;
            repeat (20) begin
                cyc(1);
                acc_and = acc_and & o_mod_power_lamp;
                acc_or = acc_or | o_mod_power_lamp;
            end
            chk("module lamp on", 32'(i_mod_present & i_mod_comm), 32'(acc_and));
            chk("module lamp any", 32'(i_mod_present), 32'(acc_or));
        end
        i_power_good = 1'b0;
        force_b = 1'b1;
        want = 1'b1;
        cyc(30);
        chk("power off", 32'h0, 32'(o_power_ok_lamp));
        chk("refused press", 32'h0, 32'(o_chan_red[0]));
        want = 1'b0;
        k = 0;
        repeat (40) begin
            cyc(1);
            if (o_reset_modules !== 1'b0) k++;
        end
        chk("refused reset", 32'h0, 32'(k));
        force_b = 1'b0;
        i_power_good = 1'b1;
        cyc(4);
        press(50, 2'b01, 1'b0);
        press(260, 2'b11, 1'b1);
        tally_and_finish;
    end
endmodule
